// file: hdl/snf_pkg.sv
package snf_pkg;

  // Command opcodes
  localparam logic [7:0] SNF_OPC_GET_FEATURE = 8'h0F;
  localparam logic [7:0] SNF_OPC_SET_FEATURE = 8'h1F;
  localparam logic [7:0] SNF_OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] SNF_OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] SNF_OPC_RESET = 8'hFF;
  localparam logic [7:0] SNF_OPC_PAGE_READ = 8'h13;
  localparam logic [7:0] SNF_OPC_PROGRAM_EXEC = 8'h10;
  localparam logic [7:0] SNF_OPC_BLOCK_ERASE = 8'hD8;

  // Feature addresses
  localparam logic [7:0] SNF_ADDR_PROTECTION = 8'hA0;
  localparam logic [7:0] SNF_ADDR_CONFIGURATION = 8'hB0;
  localparam logic [7:0] SNF_ADDR_STATUS = 8'hC0;
  localparam logic [7:0] SNF_ADDR_DRIVE = 8'hD0;

  // Reset values
  localparam logic [7:0] SNF_PROT_RESET = 8'h7C;
  localparam logic SNF_ECC_EN_RESET = 1'b1;
  localparam logic [1:0] SNF_DRIVE_RESET = 2'h1;
  localparam logic [23:0] SNF_BOOT_ROW = 24'h000000;

  // Field positions
  localparam int SNF_CFG_OTP_PROT = 7;
  localparam int SNF_CFG_OTP_EN = 6;
  localparam int SNF_CFG_FREEZE = 5;
  localparam int SNF_CFG_ECC_EN = 4;
  localparam int SNF_PROT_LOCK_A = 7;
  localparam int SNF_PROT_LOCK_B = 0;
  localparam int SNF_DRV_HI = 6;
  localparam int SNF_DRV_LO = 5;

  // Link framing
  localparam logic [2:0] SNF_BIT_LAST = 3'h7;
  localparam logic [2:0] SNF_BYTE_OPC = 3'h0;
  localparam logic [2:0] SNF_BYTE_ADDR = 3'h1;
  localparam logic [2:0] SNF_BYTE_DATA = 3'h2;
  localparam logic [2:0] SNF_BYTE_ROW_END = 3'h3;
  localparam logic [2:0] SNF_BYTE_SAT = 3'h4;

  localparam logic [1:0] SNF_ECC_CLEAN = 2'h0;

  typedef enum logic [1:0] {
    SNF_OTP_NORMAL = 2'b00,
    SNF_OTP_ACCESS = 2'b01,
    SNF_OTP_NA = 2'b10,
    SNF_OTP_LOCKED = 2'b11
  } snf_otp_mode_t;

  typedef enum logic [2:0] {
    SNF_OP_NONE = 3'b000,
    SNF_OP_READ = 3'b001,
    SNF_OP_PROGRAM = 3'b010,
    SNF_OP_ERASE = 3'b011,
    SNF_OP_RESET = 3'b100
  } snf_arr_op_t;

  typedef enum logic [1:0] {
    SNF_ST_IDLE = 2'b00,
    SNF_ST_CHECK = 2'b01,
    SNF_ST_BUSY = 2'b10
  } snf_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } snf_cmd_t;

  typedef struct packed {
    logic [7:0] prot;
    logic [7:0] cfg;
    logic [7:0] stat;
    logic [7:0] pad_drive_strength;
  } snf_snap_t;

endpackage

// file: hdl/snf_feature_regs.sv
`timescale 1ns/10ps
// How it works
// - Program/erase into protected region ignored
// - OTP enable selects OTP space, else array
// - ECC enable steers internal ECC use
// - Config bits 6 and 4 volatile writable
// - Freeze only after both lock enables set
// - OTP protect/enable pair decoded to mode
// - Get feature returns status, even while busy
// - Program fail set on failure or lock
// - Program fail cleared by program or reset
// - Erase fail set on fail, cleared start
// - Write enable sets the write latch
// - Write disable clears latch, refuses writes
// - Array-modifying ops need latch set
// - Busy flag high while operation runs
// - ECC status cleared at read/reset start
// - ECC status codes 00/01/10, 11 reserved
// - Power-up reads block 0 page 0
// - Drive strength field, default 75 percent
// - Set feature writes addressed register, except status
module snf_feature_regs
  import snf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic arr_done,
  input wire logic arr_fail,
  input wire logic [1:0] arr_ecc_status,
  input wire logic arr_target_locked,
  output logic arr_start,
  output snf_arr_op_t arr_op,
  output logic [23:0] arr_row,
  output logic arr_otp_access,
  output logic ecc_enable,
  output logic [7:0] protection_byte,
  output logic protection_freeze,
  output logic [1:0] drive_strength,
  output logic operation_busy_flag
);

  // Link side, on sck
  logic spi_clr;
  logic [2:0] bit_cnt_ff;
  logic [2:0] byte_cnt_ff;
  logic [31:0] frame_ff;
  logic [7:0] opc_ff;
  logic [7:0] fad_ff;
  logic [7:0] tx_ff;
  logic rd_ff;
  logic miso_ff;
  logic miso_oe_ff;
  snf_cmd_t cmd_hold_ff;
  logic evt_tog_ff;
  logic snap_req_s1_ff;
  logic snap_req_s2_ff;
  logic snap_ack_ff;
  logic snap_req_ff;
  snf_snap_t spi_snap_ff;

  logic [31:0] nxt_frame;
  logic [7:0] op0;
  logic byte_done;
  logic fire_single;
  logic fire_set;
  logic fire_row;
  logic fire;
  logic [31:0] nxt_hold;
  logic get_load;
  logic [7:0] get_addr;
  logic [7:0] get_byte;
  logic [2:0] nxt_byte_cnt;

  // Frame state is cleared whenever the host deselects
  assign spi_clr = cs_n | reset;
  assign nxt_frame = {frame_ff[30:0], mosi};
  assign op0 = nxt_frame[7:0];
  assign byte_done = bit_cnt_ff == SNF_BIT_LAST;
  assign nxt_byte_cnt = (byte_cnt_ff == SNF_BYTE_SAT) ? byte_cnt_ff : byte_cnt_ff + 3'h1;
  assign fire_single = byte_done && byte_cnt_ff == SNF_BYTE_OPC &&
                       (op0 == SNF_OPC_WRITE_ENABLE || op0 == SNF_OPC_WRITE_DISABLE ||
                        op0 == SNF_OPC_RESET);
  assign fire_set = byte_done && byte_cnt_ff == SNF_BYTE_DATA && opc_ff == SNF_OPC_SET_FEATURE;
  assign fire_row = byte_done && byte_cnt_ff == SNF_BYTE_ROW_END &&
                    (opc_ff == SNF_OPC_PAGE_READ || opc_ff == SNF_OPC_PROGRAM_EXEC ||
                     opc_ff == SNF_OPC_BLOCK_ERASE);
  assign fire = fire_single | fire_set | fire_row;
  assign nxt_hold = fire_single ? {op0, 24'h000000} :
                    fire_set ? {nxt_frame[23:0], 8'h00} : nxt_frame;
  assign get_load = byte_done && byte_cnt_ff != SNF_BYTE_OPC && opc_ff == SNF_OPC_GET_FEATURE;
  assign get_addr = (byte_cnt_ff == SNF_BYTE_ADDR) ? nxt_frame[7:0] : fad_ff;
  assign get_byte = (get_addr == SNF_ADDR_PROTECTION) ? spi_snap_ff.prot :
                    (get_addr == SNF_ADDR_CONFIGURATION) ? spi_snap_ff.cfg :
                    (get_addr == SNF_ADDR_STATUS) ? spi_snap_ff.stat :
                    (get_addr == SNF_ADDR_DRIVE) ? spi_snap_ff.pad_drive_strength : 8'h00;

  always_ff @(posedge sck or posedge spi_clr) begin
    if (spi_clr) begin
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
      frame_ff <= 32'h00000000;
      opc_ff <= 8'h00;
      fad_ff <= 8'h00;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      frame_ff <= nxt_frame;
      if (byte_done) begin
        byte_cnt_ff <= nxt_byte_cnt;
      end
      if (byte_done && byte_cnt_ff == SNF_BYTE_OPC) begin
        opc_ff <= op0;
      end
      if (byte_done && byte_cnt_ff == SNF_BYTE_ADDR) begin
        fad_ff <= nxt_frame[7:0];
      end
    end
  end

  // Addressed feature byte repeats every eight clocks for polling
  always_ff @(posedge sck or posedge spi_clr) begin
    if (spi_clr) begin
      tx_ff <= 8'h00;
      rd_ff <= 1'b0;
    end else if (get_load) begin
      tx_ff <= get_byte;
      rd_ff <= 1'b1;
    end else begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // Shift out on falling edge, host samples on rising
  always_ff @(negedge sck or posedge spi_clr) begin
    if (spi_clr) begin
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      miso_ff <= tx_ff[7];
      miso_oe_ff <= rd_ff;
    end
  end

  // Command word stays put until the next frame fires
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      cmd_hold_ff <= '0;
      evt_tog_ff <= 1'b0;
    end else if (fire) begin
      cmd_hold_ff <= nxt_hold;
      evt_tog_ff <= ~evt_tog_ff;
    end
  end

  snf_snap_t snap_hold_ff;

  // Snapshot handshake, link half
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      snap_req_s1_ff <= 1'b0;
      snap_req_s2_ff <= 1'b0;
      snap_ack_ff <= 1'b0;
      spi_snap_ff <= '0;
    end else begin
      snap_req_s1_ff <= snap_req_ff;
      snap_req_s2_ff <= snap_req_s1_ff;
      if (snap_req_s2_ff != snap_ack_ff) begin
        spi_snap_ff <= snap_hold_ff;
        snap_ack_ff <= snap_req_s2_ff;
      end
    end
  end

  assign miso = miso_ff;
  assign miso_oe = miso_oe_ff;

  // System side, on sys_clk
  logic evt_s1_ff, evt_s2_ff, evt_s3_ff, ack_s1_ff, ack_s2_ff;
  logic otp_prot_ff, otp_en_ff, freeze_ff, ecc_en_ff, wel_ff, pfail_ff, efail_ff;
  logic busy_ff, start_ff;
  logic [7:0] prot_ff;
  logic [1:0] drv_ff, ecc_ff;
  snf_state_t state_ff;
  snf_arr_op_t op_ff;
  logic [23:0] row_ff;

  logic evt, is_set, otp_locked, accept;
  logic want_read, want_prog, want_erase, want_reset;
  snf_cmd_t cmd;
  logic [7:0] set_addr, set_data, cfg_byte, stat_byte, odr_byte;
  snf_otp_mode_t otp_mode;
  snf_arr_op_t want_op;
  snf_state_t nxt_state;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_s1_ff <= 1'b0;
      evt_s2_ff <= 1'b0;
      evt_s3_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      evt_s1_ff <= evt_tog_ff;
      evt_s2_ff <= evt_s1_ff;
      evt_s3_ff <= evt_s2_ff;
      ack_s1_ff <= snap_ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  assign evt = evt_s2_ff ^ evt_s3_ff;
  assign cmd = cmd_hold_ff;
  assign is_set = evt && cmd.opcode == SNF_OPC_SET_FEATURE;
  assign set_addr = cmd.b1;
  assign set_data = cmd.b2;
  assign otp_mode = snf_otp_mode_t'({otp_prot_ff, otp_en_ff});
  assign otp_locked = otp_mode == SNF_OTP_LOCKED;
  assign cfg_byte = {otp_prot_ff, otp_en_ff, freeze_ff, ecc_en_ff, 4'h0};
  assign stat_byte = {2'b00, ecc_ff, pfail_ff, efail_ff, wel_ff, busy_ff};
  assign odr_byte = {1'b0, drv_ff, 5'h00};

  // Snapshot handshake, system half
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      snap_req_ff <= 1'b0;
      snap_hold_ff <= '0;
    end else if (ack_s2_ff == snap_req_ff) begin
      snap_hold_ff <= {prot_ff, cfg_byte, stat_byte, odr_byte};
      snap_req_ff <= ~snap_req_ff;
    end
  end

  assign want_read = evt && cmd.opcode == SNF_OPC_PAGE_READ;
  assign want_prog = evt && cmd.opcode == SNF_OPC_PROGRAM_EXEC;
  assign want_erase = evt && cmd.opcode == SNF_OPC_BLOCK_ERASE;
  assign want_reset = evt && cmd.opcode == SNF_OPC_RESET;
  assign accept = state_ff == SNF_ST_IDLE &&
                  (want_read || want_reset || ((want_prog || want_erase) && wel_ff));
  assign want_op = want_read ? SNF_OP_READ : want_prog ? SNF_OP_PROGRAM :
                   want_erase ? SNF_OP_ERASE : SNF_OP_RESET;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SNF_ST_IDLE: begin
        if (accept) begin
          nxt_state = SNF_ST_CHECK;
        end
      end
      SNF_ST_CHECK: begin
        if ((op_ff == SNF_OP_PROGRAM || op_ff == SNF_OP_ERASE) &&
            (arr_target_locked || (op_ff == SNF_OP_PROGRAM && otp_locked))) begin
          nxt_state = SNF_ST_IDLE;
        end else begin
          nxt_state = SNF_ST_BUSY;
        end
      end
      SNF_ST_BUSY: begin
        if (arr_done) begin
          nxt_state = SNF_ST_IDLE;
        end
      end
      default: nxt_state = SNF_ST_IDLE;
    endcase
  end

  // Power-up starts with the boot read of row zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= SNF_ST_CHECK;
      op_ff <= SNF_OP_READ;
      row_ff <= SNF_BOOT_ROW;
      busy_ff <= 1'b1;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != SNF_ST_IDLE;
      start_ff <= state_ff == SNF_ST_CHECK && nxt_state == SNF_ST_BUSY;
      if (accept) begin
        op_ff <= want_op;
        row_ff <= {cmd.b1, cmd.b2, cmd.b3};
      end
    end
  end

  logic launch;
  logic finish;
  logic refuse;
  assign launch = state_ff == SNF_ST_CHECK && nxt_state == SNF_ST_BUSY;
  assign finish = state_ff == SNF_ST_BUSY && arr_done;
  assign refuse = state_ff == SNF_ST_CHECK && nxt_state == SNF_ST_IDLE;

  // Fail and ECC flags; a setting event is placed last so it wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pfail_ff <= 1'b0;
      efail_ff <= 1'b0;
      ecc_ff <= SNF_ECC_CLEAN;
    end else begin
      if (accept && (want_op == SNF_OP_PROGRAM || want_op == SNF_OP_RESET)) begin
        pfail_ff <= 1'b0;
      end
      if (accept && (want_op == SNF_OP_ERASE || want_op == SNF_OP_RESET)) begin
        efail_ff <= 1'b0;
      end
      if (launch && (op_ff == SNF_OP_READ || op_ff == SNF_OP_RESET)) begin
        ecc_ff <= SNF_ECC_CLEAN;
      end
      if (op_ff == SNF_OP_PROGRAM && ((finish && arr_fail) || refuse)) begin
        pfail_ff <= 1'b1;
      end
      if (op_ff == SNF_OP_ERASE && ((finish && arr_fail) || refuse)) begin
        efail_ff <= 1'b1;
      end
      if (finish && op_ff == SNF_OP_READ) begin
        ecc_ff <= arr_ecc_status;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wel_ff <= 1'b0;
    end else if (evt && cmd.opcode == SNF_OPC_WRITE_ENABLE) begin
      wel_ff <= 1'b1;
    end else if (evt && (cmd.opcode == SNF_OPC_WRITE_DISABLE || cmd.opcode == SNF_OPC_RESET)) begin
      wel_ff <= 1'b0;
    end
  end

  // Feature writes; OTP protect and freeze only ever set
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      otp_prot_ff <= 1'b0;
      otp_en_ff <= 1'b0;
      freeze_ff <= 1'b0;
      ecc_en_ff <= SNF_ECC_EN_RESET;
      prot_ff <= SNF_PROT_RESET;
      drv_ff <= SNF_DRIVE_RESET;
    end else if (is_set) begin
      if (set_addr == SNF_ADDR_PROTECTION && !freeze_ff) begin
        prot_ff <= set_data;
      end
      if (set_addr == SNF_ADDR_CONFIGURATION) begin
        otp_en_ff <= set_data[SNF_CFG_OTP_EN];
        ecc_en_ff <= set_data[SNF_CFG_ECC_EN];
        if (set_data[SNF_CFG_OTP_PROT] && set_data[SNF_CFG_OTP_EN]) begin
          otp_prot_ff <= 1'b1;
        end
        if (set_data[SNF_CFG_FREEZE] && prot_ff[SNF_PROT_LOCK_A] && prot_ff[SNF_PROT_LOCK_B]) begin
          freeze_ff <= 1'b1;
        end
      end
      if (set_addr == SNF_ADDR_DRIVE) begin
        drv_ff <= set_data[SNF_DRV_HI:SNF_DRV_LO];
      end
    end
  end

  assign arr_start = start_ff;
  assign arr_op = op_ff;
  assign arr_row = row_ff;
  assign arr_otp_access = otp_en_ff;
  assign ecc_enable = ecc_en_ff;
  assign protection_byte = prot_ff;
  assign protection_freeze = freeze_ff;
  assign drive_strength = drv_ff;
  assign operation_busy_flag = busy_ff;

endmodule

// file: bench/snf_feature_regs_chk.sv
`timescale 1ns/10ps
module snf_feature_regs_chk
  import snf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic arr_done,
  input wire logic arr_target_locked,
  input wire logic arr_start,
  input wire snf_arr_op_t arr_op,
  input wire logic [23:0] arr_row,
  input wire logic ecc_enable,
  input wire logic [7:0] protection_byte,
  input wire logic [1:0] drive_strength,
  input wire logic operation_busy_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_start_one_pulse: assert property (arr_start |=> !arr_start)
    else $error("array start longer than one cycle");
  a_busy_on_start: assert property (arr_start |-> operation_busy_flag)
    else $error("array started without busy");
  a_busy_held: assert property (arr_start ##1 !arr_done |-> operation_busy_flag)
    else $error("busy dropped before completion");
  a_done_clears_busy: assert property (arr_done && operation_busy_flag |=> ##[0:1] !operation_busy_flag)
    else $error("busy not cleared after completion");
  a_start_has_op: assert property (arr_start |-> arr_op != SNF_OP_NONE)
    else $error("array start with no operation");
  a_lock_blocks_start: assert property (arr_start && (arr_op == SNF_OP_PROGRAM ||
    arr_op == SNF_OP_ERASE) |-> !$past(arr_target_locked))
    else $error("modify started on protected target");
  a_miso_idle: assert property (cs_n && $past(cs_n) |-> !miso_oe)
    else $error("miso driven while deselected");
  a_reset_values: assert property ($fell(reset) |-> ecc_enable && protection_byte ==
    SNF_PROT_RESET && drive_strength == SNF_DRIVE_RESET)
    else $error("register defaults wrong after reset");
  a_boot_read: assert property ($fell(reset) |-> ##[1:2] arr_start && arr_op == SNF_OP_READ
    && arr_row == SNF_BOOT_ROW)
    else $error("no boot read of row zero");

  c_program: cover property (arr_start && arr_op == SNF_OP_PROGRAM);
  c_erase: cover property (arr_start && arr_op == SNF_OP_ERASE);
  c_read_out: cover property (miso_oe);
endmodule

bind snf_feature_regs snf_feature_regs_chk chk_i (
  .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .miso_oe(miso_oe), .arr_done(arr_done),
  .arr_target_locked(arr_target_locked), .arr_start(arr_start), .arr_op(arr_op),
  .arr_row(arr_row), .ecc_enable(ecc_enable), .protection_byte(protection_byte),
  .drive_strength(drive_strength), .operation_busy_flag(operation_busy_flag)
);

// file: bench/snf_host_model.sv
`timescale 1ns/10ps
module snf_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // opcode, address, data
  // Clock idles low between frames; mosi toggles once released
  task automatic xfer(input logic [31:0] tx, input int nb, input int nr, output logic [7:0] rx);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < 8 * (nb + nr); i++) begin
      mosi = (i < 8 * nb) ? tx[31 - i] : ~mosi;
      #7.5 sck = 1'b1;
      if (i >= 8 * nb)
        rx = {rx[6:0], miso};
      #7.5 sck = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    mosi = ~mosi;
    // Covers snapshot lag and event spacing
    #200;
  endtask
endmodule

// file: bench/test_snf_feature_regs.sv
`timescale 1ns/10ps
module test_snf_feature_regs;
  import snf_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic arr_done = 1'b0;
  logic arr_fail = 1'b0;
  logic [1:0] arr_ecc_status = 2'h0;
  logic arr_target_locked = 1'b0;
  logic sck, cs_n, mosi, miso, miso_oe, arr_start, arr_otp_access, ecc_enable;
  logic protection_freeze, operation_busy_flag;
  logic [1:0] drive_strength;
  logic [7:0] protection_byte;
  logic [23:0] arr_row;
  snf_arr_op_t arr_op;
  int num_errors = 0;
  int tests_run = 0;
  int n_start = 0;
  int n;
  logic [7:0] rd_byte;

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (arr_start === 1'b1) n_start <= n_start + 1;

  snf_feature_regs uut (
    .sys_clk(sys_clk), .reset(reset), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .arr_done(arr_done), .arr_fail(arr_fail),
    .arr_ecc_status(arr_ecc_status), .arr_target_locked(arr_target_locked),
    .arr_start(arr_start), .arr_op(arr_op), .arr_row(arr_row),
    .arr_otp_access(arr_otp_access), .ecc_enable(ecc_enable),
    .protection_byte(protection_byte), .protection_freeze(protection_freeze),
    .drive_strength(drive_strength), .operation_busy_flag(operation_busy_flag)
  );
  snf_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  task automatic end_sim();
    $display("Comparisons: %0d, mismatches: %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic getf(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    host.xfer({SNF_OPC_GET_FEATURE, addr, 16'h0000}, 2, 1, r);
    chk({16'h0000, r}, {16'h0000, exp}, "feature read");
  endtask

  task automatic setf(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] r;
    host.xfer({SNF_OPC_SET_FEATURE, addr, data, 8'h00}, 3, 0, r);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] row, input int nb);
    logic [7:0] r;
    host.xfer({op, row}, nb, 0, r);
  endtask

  // Stands in for the array engine: waits for a start, then reports
  task automatic serve(input snf_arr_op_t op, input logic fail, input logic [1:0] ecc,
                       input int hold);
    int k;
    k = 0;
    while (arr_start !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    chk({20'h0, arr_start, arr_op}, {20'h0, 1'b1, op}, "array start and operation");
    repeat (hold) @(posedge sys_clk);
    arr_fail <= fail;
    arr_ecc_status <= ecc;
    arr_done <= 1'b1;
    @(posedge sys_clk);
    arr_done <= 1'b0;
  endtask

  initial begin
    fork serve(SNF_OP_READ, 1'b0, 2'h1, 4); join_none
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (40) @(posedge sys_clk);
    getf(SNF_ADDR_STATUS, 8'h10);
    getf(SNF_ADDR_CONFIGURATION, 8'h10);
    getf(SNF_ADDR_DRIVE, 8'h20);
    getf(SNF_ADDR_PROTECTION, SNF_PROT_RESET);
    getf(8'hE0, 8'h00);
    cmd(SNF_OPC_WRITE_ENABLE, 24'h0, 1);
    getf(SNF_ADDR_STATUS, 8'h12);
    cmd(SNF_OPC_WRITE_DISABLE, 24'h0, 1);
    getf(SNF_ADDR_STATUS, 8'h10);
    n = n_start;
    cmd(SNF_OPC_PROGRAM_EXEC, 24'h000040, 4);
    chk(24'(n_start), 24'(n), "program without latch");
    cmd(SNF_OPC_WRITE_ENABLE, 24'h0, 1);
    fork cmd(SNF_OPC_PROGRAM_EXEC, 24'h012345, 4); serve(SNF_OP_PROGRAM, 1'b1, 2'h0, 4); join
    chk(arr_row, 24'h012345, "program row");
    getf(SNF_ADDR_STATUS, 8'h1A);
    fork cmd(SNF_OPC_PROGRAM_EXEC, 24'h000041, 4); serve(SNF_OP_PROGRAM, 1'b0, 2'h0, 4); join
    getf(SNF_ADDR_STATUS, 8'h12);
    @(posedge sys_clk) arr_target_locked <= 1'b1;
    n = n_start;
    cmd(SNF_OPC_BLOCK_ERASE, 24'h000100, 4);
    chk(24'(n_start), 24'(n), "erase of protected block");
    getf(SNF_ADDR_STATUS, 8'h16);
    @(posedge sys_clk) arr_target_locked <= 1'b0;
    fork cmd(SNF_OPC_BLOCK_ERASE, 24'h000140, 4); serve(SNF_OP_ERASE, 1'b0, 2'h0, 4); join
    getf(SNF_ADDR_STATUS, 8'h12);
    fork
      begin
        cmd(SNF_OPC_PAGE_READ, 24'h000080, 4);
        getf(SNF_ADDR_STATUS, 8'h03);
      end
      serve(SNF_OP_READ, 1'b0, 2'h2, 400);
    join
    getf(SNF_ADDR_STATUS, 8'h22);
    fork cmd(SNF_OPC_RESET, 24'h0, 1); serve(SNF_OP_RESET, 1'b0, 2'h0, 4); join
    getf(SNF_ADDR_STATUS, 8'h00);
    setf(SNF_ADDR_CONFIGURATION, 8'h4F);
    getf(SNF_ADDR_CONFIGURATION, 8'h40);
    chk({22'h0, arr_otp_access, ecc_enable}, 24'h2, "otp and ecc controls");
    // Host masks the ECC field while internal ECC is off
    fork cmd(SNF_OPC_PAGE_READ, 24'h000081, 4); serve(SNF_OP_READ, 1'b0, 2'h1, 4); join
    host.xfer({SNF_OPC_GET_FEATURE, SNF_ADDR_STATUS, 16'h0000}, 2, 1, rd_byte);
    chk({16'h0000, rd_byte & 8'hCF}, 24'h000000, "status with ecc off");
    setf(SNF_ADDR_CONFIGURATION, 8'h10);
    chk({22'h0, arr_otp_access, ecc_enable}, 24'h1, "otp and ecc controls");
    for (int v = 0; v < 4; v++) begin
      setf(SNF_ADDR_DRIVE, {1'b1, 2'(v), 5'h1F});
      getf(SNF_ADDR_DRIVE, {1'b0, 2'(v), 5'h00});
      chk({22'h0, drive_strength}, 24'(v), "drive strength");
    end
    setf(SNF_ADDR_STATUS, 8'hFF);
    getf(SNF_ADDR_STATUS, 8'h10);
    setf(SNF_ADDR_PROTECTION, 8'h81);
    setf(SNF_ADDR_CONFIGURATION, 8'h30);
    chk({23'h0, protection_freeze}, 24'h1, "freeze");
    setf(SNF_ADDR_PROTECTION, 8'h00);
    getf(SNF_ADDR_PROTECTION, 8'h81);
    chk({16'h0000, protection_byte}, 24'h000081, "protection byte");
    setf(SNF_ADDR_CONFIGURATION, 8'hD0);
    getf(SNF_ADDR_CONFIGURATION, 8'hF0);
    cmd(SNF_OPC_WRITE_ENABLE, 24'h0, 1);
    n = n_start;
    cmd(SNF_OPC_PROGRAM_EXEC, 24'h000002, 4);
    chk(24'(n_start), 24'(n), "program into locked otp");
    getf(SNF_ADDR_STATUS, 8'h1A);
    end_sim();
  end

  // Whole run needs about 29 us
  initial begin
    #150000;
    num_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
